/* File: verilog/sifs_top.v */
// Signal, interrupt and FIFO service block with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "sifs_defines.vh"

module sifs_top #(
  parameter DEPTH  = 128,
  parameter PTR_W  = 7,
  parameter ADDR_W = 12
) (
  input  wire              clock_in,
  input  wire              resetn_in,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire              s_axi_awvalid_in,
  output wire              s_axi_awready_out,
  input  wire [31:0]       s_axi_wdata_in,
  input  wire [3:0]        s_axi_wstrb_in,
  input  wire              s_axi_wvalid_in,
  output wire              s_axi_wready_out,
  output reg  [1:0]        s_axi_bresp_out,
  output reg               s_axi_bvalid_out,
  input  wire              s_axi_bready_in,
  input  wire [ADDR_W-1:0] s_axi_araddr_in,
  input  wire              s_axi_arvalid_in,
  output wire              s_axi_arready_out,
  output reg  [31:0]       s_axi_rdata_out,
  output reg  [1:0]        s_axi_rresp_out,
  output reg               s_axi_rvalid_out,
  input  wire              s_axi_rready_in,
  // Pins
  input  wire              dir_pin_in,
  output wire              dir_pin_out,
  output wire              dir_pin_oe_out,
  input  wire [2:0]        gp_inputs_in,
  output wire [2:0]        gp_outputs_out,
  output wire              service_request_n_out,
  // Parallel engine side, same clock
  input  wire              strobe_issued_in,
  input  wire              ack_pulse_in,
  input  wire              timer_expired_in,
  input  wire              data_timeout_in,
  input  wire              par_push_in,
  input  wire [7:0]        par_data_in,
  input  wire              par_pop_in,
  output reg  [7:0]        par_data_out,
  output reg               par_data_valid_out,
  output wire              fifo_full_out,
  output wire              fifo_empty_out,
  output wire              mode_input_out,
  output wire              mode_periph_out
);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function is_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `SIFS_IDX_VECTOR, `SIFS_IDX_CONFIG, `SIFS_IDX_FALL_SEL,
        `SIFS_IDX_RISE_SEL, `SIFS_IDX_THRESH, `SIFS_IDX_CAUSE,
        `SIFS_IDX_SIG_STAT, `SIFS_IDX_FILL_CNT, `SIFS_IDX_DONE,
        `SIFS_IDX_FIFO, `SIFS_IDX_SIG_CTRL, `SIFS_IDX_MODE,
        `SIFS_IDX_SVC_ACK: is_mapped = 1'b1;
        default:           is_mapped = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------
  reg  [7:0]       vector, config_reg, fall_sel, rise_sel, threshold;
  reg  [3:0]       cause, sig_status, scr_wr;
  reg  [1:0]       mode;
  reg              pending, strobe_open, level_q;
  reg  [3:0]       sync1, sync2, sync3, stable;
  reg  [1:0]       settle;
  reg  [7:0]       mem [0:DEPTH-1];
  reg  [PTR_W-1:0] wptr, rptr;
  reg  [7:0]       count;
  reg              aw_held, w_held, w_lane;
  reg  [7:0]       aw_idx, w_byte;
  reg  [3:0]       next_cause, next_sig_status;
  reg  [31:0]      rd_value;

  wire [7:0] wr_idx, rd_idx, push_data;
  wire       wr_en, wr_do, rd_en, in_mode, periph;
  wire       full, empty, done_wr;
  wire       host_push, host_pop, par_push, par_pop, push, pop;
  wire [3:0] agree, new_val, sig_hit;
  wire       settled, level_now;
  wire       ev_timer, ev_signal, ev_dready, ev_stray;

  // --------------------------------------------------------------------
  // AXI4-Lite handshake
  // --------------------------------------------------------------------
  assign s_axi_awready_out = ~aw_held;
  assign s_axi_wready_out  = ~w_held;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign wr_en  = aw_held & w_held & ~s_axi_bvalid_out;
  assign wr_do  = wr_en & w_lane & is_mapped(aw_idx);
  assign wr_idx = aw_idx;
  assign rd_en  = s_axi_arvalid_in & ~s_axi_rvalid_out;
  assign rd_idx = s_axi_araddr_in[9:2];

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      aw_held          <= 1'b0;
      aw_idx           <= 8'h00;
      w_held           <= 1'b0;
      w_byte           <= 8'h00;
      w_lane           <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `SIFS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr_in[9:2];
      end
      if (s_axi_wvalid_in && !w_held)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata_in[7:0];
        w_lane <= s_axi_wstrb_in[0];
      end
      if (wr_en)
      begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= is_mapped(aw_idx) ? `SIFS_RESP_OKAY : `SIFS_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Mode, pins and signal control
  // --------------------------------------------------------------------
  assign in_mode         = mode[`SIFS_MODE_INPUT];
  assign periph          = mode[`SIFS_MODE_PERIPH];
  assign mode_input_out  = in_mode;
  assign mode_periph_out = periph;
  assign dir_pin_oe_out  = ~periph;
  assign dir_pin_out     = scr_wr[`SIFS_SCR_DIR_OUT];
  assign gp_outputs_out  = scr_wr[2:0];
  assign done_wr         = wr_do && (wr_idx == `SIFS_IDX_DONE);

  // --------------------------------------------------------------------
  // Input synchronisers and edge detection
  // --------------------------------------------------------------------
  assign agree   = ~(sync2 ^ sync3);
  assign new_val = (sync2 & agree) | (stable & ~agree);
  assign settled = (settle == `SIFS_SETTLE_CNT);
  assign sig_hit = settled ? ((stable & ~new_val & fall_sel[7:4]) |
                              (~stable & new_val & rise_sel[7:4]))
                           : 4'h0;

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync1  <= 4'h0;
      sync2  <= 4'h0;
      sync3  <= 4'h0;
      stable <= 4'h0;
      settle <= 2'h0;
    end
    else
    begin
      sync1  <= {dir_pin_in, gp_inputs_in};
      sync2  <= sync1;
      sync3  <= sync2;
      // Track pins while blind, so no false edge follows reset
      stable <= settled ? new_val : sync2;
      if (!settled)
        settle <= settle + 2'h1;
    end
  end

  // --------------------------------------------------------------------
  // FIFO
  // --------------------------------------------------------------------
  assign full      = (count == DEPTH);
  assign empty     = (count == 8'h00);
  assign fifo_full_out  = full;
  assign fifo_empty_out = empty;
  assign host_push = wr_do && (wr_idx == `SIFS_IDX_FIFO) && pending
                     && !in_mode && !full;
  assign host_pop  = rd_en && (rd_idx == `SIFS_IDX_FIFO) && pending
                     && in_mode && !empty;
  assign par_push  = par_push_in & in_mode & ~full;
  assign par_pop   = par_pop_in & ~in_mode & ~empty;
  assign push      = host_push | par_push;
  assign pop       = host_pop | par_pop;
  assign push_data = in_mode ? par_data_in : w_byte;

  always @(posedge clock_in)
  begin
    if (push)
      mem[wptr] <= push_data;
  end

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wptr               <= {PTR_W{1'b0}};
      rptr               <= {PTR_W{1'b0}};
      count              <= 8'h00;
      par_data_out       <= 8'h00;
      par_data_valid_out <= 1'b0;
    end
    else
    begin
      par_data_valid_out <= par_pop;
      if (par_pop)
        par_data_out <= mem[rptr];
      if (push)
        wptr <= wptr + {{(PTR_W-1){1'b0}}, 1'b1};
      if (pop)
        rptr <= rptr + {{(PTR_W-1){1'b0}}, 1'b1};
      if (push && !pop)
        count <= count + 8'h01;
      else if (pop && !push)
        count <= count - 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt events
  // --------------------------------------------------------------------
  assign level_now = in_mode ? (count >= threshold)
                             : (count < threshold);
  assign ev_timer  = timer_expired_in & config_reg[`SIFS_CAUSE_TIMER];
  assign ev_signal = (|sig_hit) & config_reg[`SIFS_CAUSE_SIGNAL];
  assign ev_dready = ((level_now & ~level_q) | (data_timeout_in & ~empty))
                     & config_reg[`SIFS_CAUSE_DREADY];
  assign ev_stray  = ack_pulse_in & ~strobe_open
                     & config_reg[`SIFS_CAUSE_STRAY];
  assign service_request_n_out = ~(config_reg[`SIFS_CFG_ARM] & (|cause));

  // Clears first, then sets, so a same-cycle event survives
  always @*
  begin
    next_cause      = cause;
    next_sig_status = sig_status;
    if (done_wr)
    begin
      next_cause      = 4'h0;
      next_sig_status = 4'h0;
    end
    if (wr_do && (wr_idx == `SIFS_IDX_CAUSE))
      next_cause = cause & w_byte[3:0];
    if (wr_do && (wr_idx == `SIFS_IDX_SIG_STAT))
      next_sig_status = sig_status & w_byte[7:4];
    next_sig_status = next_sig_status | sig_hit;
    next_cause = next_cause | {ev_stray, ev_dready, ev_signal, ev_timer};
  end

  // --------------------------------------------------------------------
  // Register writes and context
  // --------------------------------------------------------------------
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      vector      <= 8'h00;
      config_reg  <= 8'h00;
      fall_sel    <= 8'h00;
      rise_sel    <= 8'h00;
      threshold   <= 8'h00;
      cause       <= 4'h0;
      sig_status  <= 4'h0;
      scr_wr      <= `SIFS_SIG_CTRL_RST;
      mode        <= `SIFS_MODE_RST;
      pending     <= 1'b0;
      strobe_open <= 1'b0;
      level_q     <= 1'b0;
    end
    else
    begin
      cause      <= next_cause;
      sig_status <= next_sig_status;
      level_q    <= level_now;
      if (strobe_issued_in)
        strobe_open <= 1'b1;
      else if (ack_pulse_in)
        strobe_open <= 1'b0;
      if (rd_en && (rd_idx == `SIFS_IDX_SVC_ACK))
        pending <= 1'b1;
      else if (done_wr)
        pending <= 1'b0;
      if (wr_do)
      begin
        case (wr_idx)
          `SIFS_IDX_VECTOR:   vector     <= w_byte;
          `SIFS_IDX_CONFIG:   config_reg <= {w_byte[7], 3'h0, w_byte[3:0]};
          `SIFS_IDX_FALL_SEL: fall_sel   <= {w_byte[7:4], 4'h0};
          `SIFS_IDX_RISE_SEL: rise_sel   <= {w_byte[7:4], 4'h0};
          `SIFS_IDX_THRESH:   threshold  <= w_byte;
          `SIFS_IDX_SIG_CTRL: scr_wr     <= w_byte[3:0];
          `SIFS_IDX_MODE:     mode       <= w_byte[1:0];
          default:            ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always @*
  begin
    rd_value = 32'h0000_0000;
    case (rd_idx)
      `SIFS_IDX_VECTOR:   rd_value[7:0] = vector;
      `SIFS_IDX_CONFIG:   rd_value[7:0] = config_reg;
      `SIFS_IDX_FALL_SEL: rd_value[7:0] = fall_sel;
      `SIFS_IDX_RISE_SEL: rd_value[7:0] = rise_sel;
      `SIFS_IDX_THRESH:   rd_value[7:0] = threshold;
      `SIFS_IDX_CAUSE:    rd_value[7:0] = {|cause, 3'h0, cause};
      `SIFS_IDX_SIG_STAT: rd_value[7:0] = {sig_status, 4'h0};
      `SIFS_IDX_FILL_CNT: rd_value[7:0] = count;
      `SIFS_IDX_FIFO:     rd_value[7:0] = host_pop ? mem[rptr] : 8'h00;
      `SIFS_IDX_SIG_CTRL: rd_value[7:0] = {stable, scr_wr};
      `SIFS_IDX_MODE:     rd_value[7:0] = {pending, 5'h00, mode};
      `SIFS_IDX_SVC_ACK:  rd_value[7:0] = vector;
      default:            rd_value = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `SIFS_RESP_OKAY;
    end
    else if (rd_en)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_value;
      s_axi_rresp_out  <= is_mapped(rd_idx) ? `SIFS_RESP_OKAY : `SIFS_RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

endmodule // sifs_top

/* File: verilog/sifs_defines.vh */
// Register indices, field positions and reset values of the service block
`ifndef SIFS_DEFINES_VH
`define SIFS_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SIFS_IDX_VECTOR   8'h00
`define SIFS_IDX_CONFIG   8'h01
`define SIFS_IDX_FALL_SEL 8'h06
`define SIFS_IDX_RISE_SEL 8'h07
`define SIFS_IDX_THRESH   8'h08
`define SIFS_IDX_CAUSE    8'h0C
`define SIFS_IDX_SIG_STAT 8'h0D
`define SIFS_IDX_FILL_CNT 8'h0E
`define SIFS_IDX_DONE     8'h60
`define SIFS_IDX_FIFO     8'h62
`define SIFS_IDX_SIG_CTRL 8'h6E
`define SIFS_IDX_MODE     8'h70
`define SIFS_IDX_SVC_ACK  8'h71

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SIFS_CFG_ARM      7
`define SIFS_CAUSE_TIMER  0
`define SIFS_CAUSE_SIGNAL 1
`define SIFS_CAUSE_DREADY 2
`define SIFS_CAUSE_STRAY  3
`define SIFS_CAUSE_ANY    7
`define SIFS_MODE_PERIPH  0
`define SIFS_MODE_INPUT   1
`define SIFS_MODE_PENDING 7
`define SIFS_SCR_DIR_OUT  3

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SIFS_SIG_CTRL_RST 4'h8
`define SIFS_MODE_RST     2'h0
`define SIFS_SETTLE_CNT   2'h3
`define SIFS_RESP_OKAY    2'h0
`define SIFS_RESP_SLVERR  2'h2

`endif

/* File: tb/sifs_monitor.sv */
// Port checker for the service block
`timescale 1ns/100ps
module sifs_monitor (
  input wire        clock_in,
  input wire        resetn_in,
  input wire        dir_pin_out,
  input wire        dir_pin_oe_out,
  input wire [2:0]  gp_outputs_out,
  input wire        service_request_n_out,
  input wire        fifo_full_out,
  input wire        fifo_empty_out,
  input wire        mode_input_out,
  input wire        mode_periph_out,
  input wire        par_push_in,
  input wire        par_pop_in,
  input wire        par_data_valid_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in,
  input wire        s_axi_rvalid_out,
  input wire        s_axi_rready_in,
  input wire [31:0] s_axi_rdata_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  // ----------
  // Properties
  // ----------
  sequence s_pop_req;
    par_pop_in && !mode_input_out && !fifo_empty_out;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid_out && !s_axi_rready_in;
  endsequence
  property p_reset_state;
    $rose(resetn_in) |-> dir_pin_oe_out && dir_pin_out && (gp_outputs_out == 3'h0)
      && service_request_n_out && fifo_empty_out;
  endproperty
  property p_dir_oe;
    $stable(mode_periph_out) |-> dir_pin_oe_out != mode_periph_out;
  endproperty
  property p_one_end;
    !(fifo_full_out && fifo_empty_out);
  endproperty
  property p_push;
    par_push_in && mode_input_out && fifo_empty_out |=> !fifo_empty_out;
  endproperty
  property p_pop;
    s_pop_req |=> par_data_valid_out;
  endproperty
  property p_no_pop;
    !par_pop_in |=> !par_data_valid_out;
  endproperty
  property p_b_stand;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
  endproperty
  property p_r_stand;
    s_r_wait |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  a_dir_oe: assert property (p_dir_oe) else $error("direction drive wrong");
  a_one_end: assert property (p_one_end) else $error("full and empty");
  a_push: assert property (p_push) else $error("push lost");
  a_pop: assert property (p_pop) else $error("pop gave no byte");
  a_no_pop: assert property (p_no_pop) else $error("byte without pop");
  a_b_stand: assert property (p_b_stand) else $error("bvalid dropped");
  a_r_stand: assert property (p_r_stand) else $error("read data moved");
endmodule // sifs_monitor

bind sifs_top sifs_monitor u_mon (.*);

/* File: tb/sifs_engine_model.sv */
// Parallel engine model on the far side of the FIFO and event ports
`timescale 1ns/100ps
module sifs_engine_model (
  input  wire        clock_in,
  input  wire        dir_oe_in,
  input  wire        dir_drive_in,
  input  wire [7:0]  pop_data_in,
  input  wire        pop_valid_in,
  output logic [3:0] event_out,
  output logic       push_out,
  output logic [7:0] push_data_out,
  output logic       pop_out,
  output logic [2:0] gp_out,
  output wire        dir_level_out,
  output logic [7:0] popped_out
);
  logic ext_dir = 1'b0;
  initial
  begin
    event_out = 4'h0;
    push_out = 1'b0;
    push_data_out = 8'h00;
    pop_out = 1'b0;
    gp_out = 3'h0;
    popped_out = 8'h00;
  end
  // Wire level: device in controller mode, else far side
  assign dir_level_out = dir_oe_in ? dir_drive_in : ext_dir;
  always @(posedge clock_in)
    if (pop_valid_in)
      popped_out <= pop_data_in;
  // One-cycle event: 0 timer, 1 ack, 2 strobe, 3 timeout
  task pulse(input [1:0] k);
    @(posedge clock_in);
    event_out[k] <= 1'b1;
    @(posedge clock_in);
    event_out <= 4'h0;
  endtask
  task push(input [7:0] d);
    @(posedge clock_in);
    push_out <= 1'b1;
    push_data_out <= d;
    @(posedge clock_in);
    push_out <= 1'b0;
    push_data_out <= ~d;
  endtask
  task pop;
    @(posedge clock_in);
    pop_out <= 1'b1;
    @(posedge clock_in);
    pop_out <= 1'b0;
  endtask
  task set_gp(input [2:0] v);
    @(posedge clock_in);
    gp_out <= v;
  endtask
  task set_dir(input v);
    @(posedge clock_in);
    ext_dir <= v;
  endtask
endmodule // sifs_engine_model

/* File: tb/tb_top.sv */
// Self-checking testbench for the service block
`timescale 1ns/100ps
`define CHK(n, e, a) \
  begin \
    tests_run++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s at %h exp %h got %h", n, cur, e, a); \
    end \
  end
module tb_top;
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [11:0] s_axi_awaddr_in = 12'h000;
  logic [11:0] s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire         s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0]  s_axi_rdata_out;
  wire         dir_pin_in, dir_pin_out, dir_pin_oe_out, service_request_n_out;
  wire         fifo_full_out, fifo_empty_out, mode_input_out, mode_periph_out;
  wire         strobe_issued_in, ack_pulse_in, timer_expired_in, data_timeout_in;
  wire         par_push_in, par_pop_in, par_data_valid_out;
  wire [2:0]   gp_inputs_in, gp_outputs_out;
  wire [7:0]   par_data_in, par_data_out, popped;
  wire [3:0]   ev;
  logic [7:0]  rd_q, ri, rw, rr, ec, ee;
  logic [7:0]  cur = 8'h00;
  logic [1:0]  rsp_q, brsp_q, re, ek;
  logic        en;
  int          failures = 0, tests_run = 0, cycles = 0;
  logic [25:0] rows [8] = '{
    {8'h00, 8'hA5, 8'hA5, 2'h0}, {8'h01, 8'hFF, 8'h8F, 2'h0},
    {8'h06, 8'hFF, 8'hF0, 2'h0}, {8'h07, 8'hFF, 8'hF0, 2'h0},
    {8'h08, 8'h81, 8'h81, 2'h0}, {8'h6E, 8'hF5, 8'h55, 2'h0},
    {8'h60, 8'h00, 8'h00, 2'h0}, {8'h20, 8'h5A, 8'h00, 2'h2}};
  logic [18:0] evr [5] = '{
    {8'h01, 2'h0, 8'h81, 1'b1}, {8'h81, 2'h0, 8'h81, 1'b0},
    {8'h00, 2'h0, 8'h00, 1'b1}, {8'h88, 2'h1, 8'h88, 1'b0},
    {8'h80, 2'h1, 8'h00, 1'b1}};
  assign {data_timeout_in, strobe_issued_in, ack_pulse_in, timer_expired_in} = ev;
  sifs_top dut (.*);
  sifs_engine_model eng (.clock_in(clock_in), .dir_oe_in(dir_pin_oe_out),
    .dir_drive_in(dir_pin_out), .pop_data_in(par_data_out),
    .pop_valid_in(par_data_valid_out), .event_out(ev), .push_out(par_push_in),
    .push_data_out(par_data_in), .pop_out(par_pop_in), .gp_out(gp_inputs_in),
    .dir_level_out(dir_pin_in), .popped_out(popped));
  always #25 clock_in = ~clock_in;
  // ----------
  // Bus master: release each channel when taken
  // ----------
  always @(posedge clock_in)
  begin
    if (s_axi_awvalid_in && s_axi_awready_out)
      s_axi_awvalid_in <= 1'b0;
    if (s_axi_wvalid_in && s_axi_wready_out)
      s_axi_wvalid_in <= 1'b0;
    if (s_axi_bready_in && s_axi_bvalid_out)
    begin
      s_axi_bready_in <= 1'b0;
      brsp_q <= s_axi_bresp_out;
    end
    if (s_axi_arvalid_in && s_axi_arready_out)
      s_axi_arvalid_in <= 1'b0;
    if (s_axi_rready_in && s_axi_rvalid_out)
    begin
      s_axi_rready_in <= 1'b0;
      rsp_q <= s_axi_rresp_out;
      rd_q <= s_axi_rdata_out[7:0];
    end
  end
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      failures++;
      summarize();
    end
  end
  task wr(input [7:0] i, input [7:0] d);
    @(posedge clock_in);
    cur <= i;
    s_axi_awaddr_in <= {2'b00, i, 2'b00};
    s_axi_wdata_in <= {24'h00_0000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    s_axi_bready_in <= 1'b1;
    @(posedge clock_in);
    while (s_axi_bready_in) @(posedge clock_in);
  endtask
  task rd(input [7:0] i);
    @(posedge clock_in);
    cur <= i;
    s_axi_araddr_in <= {2'b00, i, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    s_axi_rready_in <= 1'b1;
    @(posedge clock_in);
    while (s_axi_rready_in) @(posedge clock_in);
  endtask
  task chk_rd(input [7:0] i, input [7:0] e);
    rd(i);
    `CHK("rdata", e, rd_q)
  endtask
  task summarize;
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    `CHK("oe", 1'b1, dir_pin_oe_out)
    `CHK("gp_out", 3'h0, gp_outputs_out)
    `CHK("req_n", 1'b1, service_request_n_out)
    chk_rd(8'h6E, 8'h88);
    chk_rd(8'h70, 8'h00);
    chk_rd(8'h0E, 8'h00);
    eng.set_gp(3'h5);
    foreach (rows[k])
    begin
      {ri, rw, rr, re} = rows[k];
      wr(ri, rw);
      `CHK("bresp", re, brsp_q)
      repeat (4) @(posedge clock_in);
      rd(ri);
      `CHK("rdata", rr, rd_q)
      `CHK("rresp", re, rsp_q)
    end
    `CHK("gp_out", 3'h5, gp_outputs_out)
    s_axi_wstrb_in <= 4'hE;
    wr(8'h00, 8'h3C);
    s_axi_wstrb_in <= 4'hF;
    `CHK("bresp", 2'h0, brsp_q)
    chk_rd(8'h00, 8'hA5);
    wr(8'h70, 8'h01);
    wr(8'h6E, 8'h08);
    repeat (4) @(posedge clock_in);
    `CHK("oe", 1'b0, dir_pin_oe_out)
    chk_rd(8'h6E, 8'h58);
    eng.set_dir(1'b1);
    repeat (6) @(posedge clock_in);
    chk_rd(8'h6E, 8'hD8);
    wr(8'h70, 8'h00);
    wr(8'h06, 8'h20);
    wr(8'h07, 8'h10);
    wr(8'h01, 8'h82);
    wr(8'h60, 8'h00);
    eng.set_gp(3'h4);
    repeat (6) @(posedge clock_in);
    chk_rd(8'h0D, 8'h00);
    eng.set_gp(3'h5);
    repeat (6) @(posedge clock_in);
    chk_rd(8'h0D, 8'h10);
    chk_rd(8'h0C, 8'h82);
    `CHK("req_n", 1'b0, service_request_n_out)
    eng.set_gp(3'h7);
    repeat (6) @(posedge clock_in);
    eng.set_gp(3'h5);
    repeat (6) @(posedge clock_in);
    chk_rd(8'h0D, 8'h30);
    wr(8'h60, 8'h00);
    chk_rd(8'h0D, 8'h00);
    chk_rd(8'h0C, 8'h00);
    foreach (evr[k])
    begin
      {ec, ek, ee, en} = evr[k];
      wr(8'h01, ec);
      eng.pulse(ek);
      chk_rd(8'h0C, ee);
      `CHK("req_n", en, service_request_n_out)
      wr(8'h0C, 8'h00);
      chk_rd(8'h0C, 8'h00);
    end
    wr(8'h01, 8'h88);
    eng.pulse(2'h2);
    eng.pulse(2'h1);
    chk_rd(8'h0C, 8'h00);
    wr(8'h70, 8'h02);
    wr(8'h08, 8'h02);
    wr(8'h01, 8'h84);
    wr(8'h0C, 8'h00);
    eng.push(8'h3C);
    chk_rd(8'h0C, 8'h00);
    eng.push(8'hC3);
    chk_rd(8'h0C, 8'h84);
    chk_rd(8'h62, 8'h00);
    chk_rd(8'h0E, 8'h02);
    chk_rd(8'h71, 8'hA5);
    chk_rd(8'h62, 8'h3C);
    chk_rd(8'h62, 8'hC3);
    chk_rd(8'h0E, 8'h00);
    chk_rd(8'h70, 8'h82);
    wr(8'h60, 8'h00);
    chk_rd(8'h70, 8'h02);
    eng.push(8'h11);
    eng.pulse(2'h3);
    chk_rd(8'h0C, 8'h84);
    rd(8'h71);
    chk_rd(8'h62, 8'h11);
    wr(8'h60, 8'h00);
    wr(8'h70, 8'h00);
    wr(8'h0C, 8'h00);
    rd(8'h71);
    wr(8'h62, 8'h5A);
    wr(8'h62, 8'hA6);
    wr(8'h62, 8'h77);
    wr(8'h60, 8'h00);
    wr(8'h62, 8'h99);
    chk_rd(8'h0E, 8'h03);
    eng.pop();
    chk_rd(8'h0C, 8'h00);
    `CHK("popped", 8'h5A, popped)
    eng.pop();
    chk_rd(8'h0C, 8'h84);
    `CHK("popped", 8'hA6, popped)
    resetn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    `CHK("req_n", 1'b1, service_request_n_out)
    chk_rd(8'h0E, 8'h00);
    chk_rd(8'h0C, 8'h00);
    chk_rd(8'h6E, 8'hD8);
    summarize();
  end
endmodule // tb_top
